// ==== inc/rtc_reset_defines.vh ====
`ifndef RTC_RESET_DEFINES_VH
`define RTC_RESET_DEFINES_VH

// register offsets
`define REG_CTRL_OFS          8'h00
`define REG_RESET_CMD_OFS     8'h05
`define REG_CENTI_OFS         8'h06
`define REG_SECONDS_OFS       8'h07

// reset command codes
`define CMD_SOFT_RESET        8'h2c
`define CMD_DIVIDER_CLEAR     8'ha4
`define CMD_TS_CLEAR          8'h25
`define CMD_DIV_TS_CLEAR      8'ha5
`define RESET_CMD_READBACK    8'h24

// seconds register layout
`define SEC_OSC_HALT_BIT      7
`define SEC_OSC_HALT_RESET    1'b1

// control register layout
`define CTRL_ARM_BIT          0
`define CTRL_H12_BIT          1
`define CTRL_TC_OFF_BIT       2
`define CTRL_CENTI_OFF_BIT    3
`define CTRL_CLOCK_OUTPUT_PIN_OFF_BIT   4
`define CTRL_PWR_LSB          5
`define CTRL_PWR_MSB          7
`define CTRL_RESET            8'he0
`define CTRL_ARM_RESET        1'b0

// hundredths register
`define CENTI_RESET           8'h00

// timing
`define CLK_PERIOD_NS         5
`define BYPASS_PHASE_MIN_NS   100
`define BYPASS_PHASE_CYC      ((`BYPASS_PHASE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BYPASS_CNT_W          8

`endif

// ==== rtl/level_sync.v ====
`timescale 1ns/100ps
`default_nettype none

module level_sync (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // asynchronous levels in, synchronised levels out
   input  wire [4:0] async_in,
   output wire [4:0] sync_out
);

   reg [4:0] meta_r;
   reg [4:0] stable_r;

   // meta_r feeds stable_r only
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r   <= 5'h00;
         stable_r <= 5'h00;
      end else begin
         meta_r   <= async_in;
         stable_r <= meta_r;
      end
   end

   assign sync_out = stable_r;

endmodule // level_sync

`default_nettype wire

// ==== rtl/centi_bcd_counter.v ====
`timescale 1ns/100ps
`default_nettype none
`include "rtc_reset_defines.vh"

module centi_bcd_counter (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // control
   input  wire       hold_clear,
   input  wire       tick,
   input  wire       load,
   input  wire [7:0] load_val,
   // state
   output reg  [7:0] centi_r,
   output reg        wrap_r
);

   wire units_top = (centi_r[3:0] == 4'h9);
   wire tens_top  = (centi_r[7:4] == 4'h9);

   always @(posedge clk_sys) begin
      if (!rst_n || hold_clear) begin
         centi_r <= `CENTI_RESET;
         wrap_r  <= 1'b0;
      end else if (load) begin
         centi_r <= load_val;
         wrap_r  <= 1'b0;
      end else if (tick) begin
         wrap_r <= units_top && tens_top;
         if (!units_top)
            centi_r[3:0] <= centi_r[3:0] + 4'h1;
         else begin
            centi_r[3:0] <= 4'h0;
            centi_r[7:4] <= tens_top ? 4'h0 : centi_r[7:4] + 4'h1;
         end
      end else begin
         wrap_r <= 1'b0;
      end
   end

endmodule // centi_bcd_counter

`default_nettype wire

// ==== rtl/rtc_reset_and_osc_stop_control.v ====
//
// Function
// - oscillator supply out of range forces internal reset and sets the halt flag
// - after power-on, reset holds until oscillator runs and supply is good
// - halt flag stays 1 after reset until the host writes it to 0
// - supply below the low level counts as oscillator supply failure, reset held
// - power-on reset held for the whole oscillator start-up interval
// - every internal reset, any cause, sets the halt flag
// - power-on reset loads clock output, 24-hour, switch-over off, compensation, hundredths defaults
// - detected bypass pattern releases reset at once
// - writing arm to 0 leaves bypass mode and blocks re-entry
// - command 2ch gives soft reset plus divider clear and timestamp clear
// - command a4h clears only the time divider
// - command 25h zeroes the timestamp registers
// - command a5h clears divider and timestamps together
// - reading the reset command register returns 24h
// - any other command value is ignored
// - soft reset restores defaults but keeps bypass state and fuse status
// - hundredths register counts 00 to 99 in bcd, resets to zero
// - halt flag is bit 7 of seconds register 07h, resets to 1
//
`timescale 1ns/100ps
`default_nettype none
`include "rtc_reset_defines.vh"

module rtc_reset_and_osc_stop_control (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // analog monitor levels
   input  wire       osc_running_in,
   input  wire       supply_ok_in,
   input  wire       osc_supply_ok_in,
   // serial interface pins, watched for the bypass pattern
   input  wire       sda_ce_in,
   input  wire       scl_in,
   // register access from the serial front end
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_rvalid,
   // time base
   input  wire       tick_centi,
   input  wire [6:0] seconds_in,
   // reset and command outputs
   output reg        chip_reset,
   output reg        soft_reset_cmd,
   output reg        divider_clear_cmd,
   output reg        ts_clear,
   output wire       centi_wrap,
   // mode outputs
   output reg        reset_bypass_mode,
   output wire       reset_bypass_arm,
   output reg        osc_halt_flag,
   output wire       clock_output_pin_en,
   output wire       hour_mode_24,
   output wire [2:0] batt_mode,
   output wire       temp_comp_en,
   output wire       centi_en
);

   localparam [1:0] PAT_IDLE   = 2'd0;
   localparam [1:0] PAT_SDA_LO = 2'd1;
   localparam [1:0] PAT_SCL_LO = 2'd2;
   localparam [1:0] PAT_SCL_HI = 2'd3;

   localparam integer             PHASE_CYC_INT = `BYPASS_PHASE_CYC;
   localparam [`BYPASS_CNT_W-1:0] PHASE_CYC     = PHASE_CYC_INT[`BYPASS_CNT_W-1:0];
   localparam [7:0]               CTRL_DEF      = `CTRL_RESET;

   wire [4:0] sync_lv;
   wire       osc_run_s;
   wire       supply_ok_s;
   wire       osc_sup_ok_s;
   wire       sda_s;
   wire       scl_s;

   reg  [7:0] ctrl_r;
   reg  [7:0] ctrl_nxt;
   reg        soft_pend_r;
   reg        chip_reset_nxt;
   reg        flag_nxt;
   reg  [1:0] pat_r;
   reg  [1:0] pat_nxt;
   reg  [`BYPASS_CNT_W-1:0] phase_cnt_r;
   reg  [`BYPASS_CNT_W-1:0] phase_cnt_nxt;
   reg        bypass_nxt;
   reg  [7:0] rdata_nxt;

   wire [7:0] centi_val;
   wire       wr_cmd;
   wire       wr_ctrl;
   wire       wr_sec;
   wire       wr_centi;
   wire       cmd_soft;
   wire       cmd_div;
   wire       cmd_ts;
   wire       arm_clear;
   wire       supply_fail;
   wire       osc_stopped;
   wire       phase_done;

   // monitor levels and pins come from outside this clock domain
   level_sync u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in ({scl_in, sda_ce_in, osc_supply_ok_in, supply_ok_in, osc_running_in}),
      .sync_out (sync_lv)
   );

   assign osc_run_s    = sync_lv[0];
   assign supply_ok_s  = sync_lv[1];
   assign osc_sup_ok_s = sync_lv[2];
   assign sda_s        = sync_lv[3];
   assign scl_s        = sync_lv[4];

   assign wr_cmd   = reg_wr && (reg_addr == `REG_RESET_CMD_OFS);
   assign wr_ctrl  = reg_wr && (reg_addr == `REG_CTRL_OFS);
   assign wr_sec   = reg_wr && (reg_addr == `REG_SECONDS_OFS);
   assign wr_centi = reg_wr && (reg_addr == `REG_CENTI_OFS);

   // unknown codes decode to nothing
   assign cmd_soft = wr_cmd && (reg_wdata == `CMD_SOFT_RESET);
   assign cmd_div  = wr_cmd && ((reg_wdata == `CMD_SOFT_RESET) ||
                                (reg_wdata == `CMD_DIVIDER_CLEAR) ||
                                (reg_wdata == `CMD_DIV_TS_CLEAR));
   assign cmd_ts   = wr_cmd && ((reg_wdata == `CMD_SOFT_RESET) ||
                                (reg_wdata == `CMD_TS_CLEAR) ||
                                (reg_wdata == `CMD_DIV_TS_CLEAR));

   assign arm_clear = wr_ctrl && !reg_wdata[`CTRL_ARM_BIT];

   // low supply takes the oscillator supply down with it
   assign supply_fail = !supply_ok_s || !osc_sup_ok_s;
   assign osc_stopped = !osc_run_s;

   // reset cause merge; bypass only masks the oscillator start-up wait
   always @* begin
      chip_reset_nxt = supply_fail ||
                       (osc_stopped && !reset_bypass_mode) ||
                       soft_pend_r;
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         chip_reset  <= 1'b1;
         soft_pend_r <= 1'b0;
      end else begin
         chip_reset  <= chip_reset_nxt;
         soft_pend_r <= cmd_soft;
      end
   end

   // command pulses, one cycle each
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         soft_reset_cmd    <= 1'b0;
         divider_clear_cmd <= 1'b0;
         ts_clear          <= 1'b0;
      end else begin
         soft_reset_cmd    <= cmd_soft;
         divider_clear_cmd <= cmd_div;
         ts_clear          <= cmd_ts;
      end
   end

   // halt flag: any reset sets it, set wins over a host clear
   always @* begin
      flag_nxt = osc_halt_flag;
      if (wr_sec && !reg_wdata[`SEC_OSC_HALT_BIT])
         flag_nxt = 1'b0;
      if (chip_reset || chip_reset_nxt)
         flag_nxt = 1'b1;
   end

   always @(posedge clk_sys) begin
      if (!rst_n)
         osc_halt_flag <= `SEC_OSC_HALT_RESET;
      else
         osc_halt_flag <= flag_nxt;
   end

   // control register; arm survives internal and soft reset
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
         ctrl_nxt = reg_wdata;
      if (chip_reset)
         ctrl_nxt = {CTRL_DEF[7:1], ctrl_nxt[`CTRL_ARM_BIT]};
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r                <= `CTRL_RESET;
         ctrl_r[`CTRL_ARM_BIT] <= `CTRL_ARM_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign reset_bypass_arm = ctrl_r[`CTRL_ARM_BIT];
   assign hour_mode_24     = !ctrl_r[`CTRL_H12_BIT];
   assign temp_comp_en     = !ctrl_r[`CTRL_TC_OFF_BIT];
   assign centi_en         = !ctrl_r[`CTRL_CENTI_OFF_BIT];
   assign clock_output_pin_en        = !ctrl_r[`CTRL_CLOCK_OUTPUT_PIN_OFF_BIT];
   assign batt_mode        = ctrl_r[`CTRL_PWR_MSB:`CTRL_PWR_LSB];

   // bypass entry pattern: data low with clock high, clock low, clock high,
   // then data high; each phase held for the minimum time
   assign phase_done = (phase_cnt_r >= PHASE_CYC);

   always @* begin
      pat_nxt       = pat_r;
      phase_cnt_nxt = phase_done ? phase_cnt_r : phase_cnt_r + 1'b1;
      bypass_nxt    = reset_bypass_mode;
      case (pat_r)
         PAT_IDLE: begin
            phase_cnt_nxt = {`BYPASS_CNT_W{1'b0}};
            if (!sda_s && scl_s)
               pat_nxt = PAT_SDA_LO;
         end
         PAT_SDA_LO: begin
            if (sda_s)
               pat_nxt = PAT_IDLE;
            else if (!scl_s) begin
               pat_nxt       = phase_done ? PAT_SCL_LO : PAT_IDLE;
               phase_cnt_nxt = {`BYPASS_CNT_W{1'b0}};
            end
         end
         PAT_SCL_LO: begin
            if (scl_s) begin
               pat_nxt       = phase_done ? PAT_SCL_HI : PAT_IDLE;
               phase_cnt_nxt = {`BYPASS_CNT_W{1'b0}};
            end
         end
         PAT_SCL_HI: begin
            if (!scl_s)
               pat_nxt = PAT_IDLE;
            else if (sda_s) begin
               pat_nxt    = PAT_IDLE;
               bypass_nxt = phase_done;
            end
         end
         default: begin
            pat_nxt = PAT_IDLE;
         end
      endcase
      // disarmed: no new entry and any active bypass ends
      if (!reset_bypass_arm || arm_clear) begin
         pat_nxt    = PAT_IDLE;
         bypass_nxt = 1'b0;
      end
   end

   // bypass state is untouched by soft reset; power-on, disarming or a pattern with a short last phase clears it
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         pat_r             <= PAT_IDLE;
         phase_cnt_r       <= {`BYPASS_CNT_W{1'b0}};
         reset_bypass_mode <= 1'b0;
      end else begin
         pat_r             <= pat_nxt;
         phase_cnt_r       <= phase_cnt_nxt;
         reset_bypass_mode <= bypass_nxt;
      end
   end

   // hundredths counter, frozen at zero during reset
   centi_bcd_counter u_centi (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .hold_clear (chip_reset),
      .tick       (tick_centi && centi_en),
      .load       (wr_centi),
      .load_val   (reg_wdata),
      .centi_r    (centi_val),
      .wrap_r     (centi_wrap)
   );

   // read path, data one cycle after the strobe
   always @* begin
      case (reg_addr)
         `REG_RESET_CMD_OFS: rdata_nxt = `RESET_CMD_READBACK;
         `REG_CENTI_OFS:     rdata_nxt = centi_val;
         `REG_SECONDS_OFS:   rdata_nxt = {osc_halt_flag, seconds_in};
         `REG_CTRL_OFS:      rdata_nxt = ctrl_r;
         default:            rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= reg_rd ? rdata_nxt : reg_rdata;
         reg_rvalid <= reg_rd;
      end
   end

endmodule // rtc_reset_and_osc_stop_control

`default_nettype wire

// ==== tb/rst_checks_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

module rst_checks (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // monitors and register port
   input wire logic       osc_running_in,
   input wire logic       supply_ok_in,
   input wire logic       osc_supply_ok_in,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // reset, commands and modes
   input wire logic       chip_reset,
   input wire logic       soft_reset_cmd,
   input wire logic       divider_clear_cmd,
   input wire logic       ts_clear,
   input wire logic       reset_bypass_mode,
   input wire logic       reset_bypass_arm,
   input wire logic       osc_halt_flag,
   input wire logic       clock_output_pin_en,
   input wire logic       hour_mode_24,
   input wire logic [2:0] batt_mode,
   input wire logic       temp_comp_en,
   input wire logic       centi_en
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // four samples cover the two sync flops and the reset register
   sequence s_supply_lost; (!supply_ok_in) [*4]; endsequence
   sequence s_osc_lost; (!osc_supply_ok_in) [*4]; endsequence
   sequence s_cmd(d); reg_wr && reg_addr == 8'h05 && reg_wdata == d; endsequence
   sequence s_defaults; clock_output_pin_en && hour_mode_24 && batt_mode == 3'h7 && temp_comp_en && centi_en; endsequence

   property p_soft; s_cmd(8'h2c) |=> soft_reset_cmd && divider_clear_cmd && ts_clear; endproperty
   property p_div; s_cmd(8'ha4) |=> divider_clear_cmd && !ts_clear && !soft_reset_cmd; endproperty
   property p_ts; s_cmd(8'h25) |=> ts_clear && !divider_clear_cmd && !soft_reset_cmd; endproperty
   property p_both; s_cmd(8'ha5) |=> divider_clear_cmd && ts_clear && !soft_reset_cmd; endproperty
   property p_readback; reg_rd && reg_addr == 8'h05 |=> reg_rvalid && reg_rdata == 8'h24; endproperty
   property p_reset_flag; chip_reset |=> osc_halt_flag; endproperty
   property p_sticky; osc_halt_flag && !(reg_wr && reg_addr == 8'h07 && !reg_wdata[7]) |=> osc_halt_flag; endproperty
   property p_supply; s_supply_lost |-> chip_reset; endproperty
   property p_osc_supply; s_osc_lost |-> chip_reset; endproperty
   property p_unarm; reg_wr && reg_addr == 8'h00 && !reg_wdata[0] |=> !reset_bypass_mode && !reset_bypass_arm;
   endproperty
   property p_bypass; $rose(reset_bypass_mode) && supply_ok_in && osc_supply_ok_in |=> !chip_reset; endproperty
   property p_por_hold; (!osc_running_in && !reset_bypass_mode) [*4] |-> chip_reset; endproperty
   property p_por_defaults; $rose(rst_n) |-> s_defaults and osc_halt_flag; endproperty
   property p_soft_defaults; soft_reset_cmd |-> ##2 s_defaults; endproperty

   a_soft: assert property (p_soft) else $error("soft reset command pulses wrong");
   a_div: assert property (p_div) else $error("divider clear command pulses wrong");
   a_ts: assert property (p_ts) else $error("timestamp clear command pulses wrong");
   a_both: assert property (p_both) else $error("combined clear command pulses wrong");
   a_readback: assert property (p_readback) else $error("command register readback wrong");
   a_reset_flag: assert property (p_reset_flag) else $error("reset left halt flag clear");
   a_sticky: assert property (p_sticky) else $error("halt flag cleared without write");
   a_supply: assert property (p_supply) else $error("low supply without reset");
   a_osc_supply: assert property (p_osc_supply) else $error("oscillator supply fault without reset");
   a_unarm: assert property (p_unarm) else $error("disarm did not leave bypass");
   a_bypass: assert property (p_bypass) else $error("bypass did not release reset");
   a_por_hold: assert property (p_por_hold) else $error("reset released with oscillator stopped");
   a_por_defaults: assert property (p_por_defaults) else $error("power-on defaults wrong");
   a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset defaults wrong");
endmodule // rst_checks

bind rtc_reset_and_osc_stop_control rst_checks chk (.*);

`default_nettype wire

// ==== tb/host_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module host_pin_model (
   // clock
   input  wire logic       clk_sys,
   // control from the bench
   input  wire logic       start,
   input  wire logic [7:0] phase_len,
   // serial pins
   output logic            sda_ce,
   output logic            scl,
   output logic            done
);
   // idle pins sit high as on pulled-up lines
   initial begin
      sda_ce = 1'b1;
      scl = 1'b1;
      done = 1'b0;
   end
   always begin
      @(posedge clk_sys);
      if (start === 1'b1 && done === 1'b0) begin
         #1 sda_ce = 1'b0;
         repeat (phase_len) @(posedge clk_sys);
         #1 scl = 1'b0;
         repeat (phase_len) @(posedge clk_sys);
         #1 scl = 1'b1;
         repeat (phase_len) @(posedge clk_sys);
         #1 sda_ce = 1'b1;
         done = 1'b1;
      end else if (start !== 1'b1) begin
         #1 done = 1'b0;
      end
   end
endmodule // host_pin_model

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       osc_running_in = 1'b0;
   logic       supply_ok_in = 1'b1;
   logic       osc_supply_ok_in = 1'b1;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       tick_centi = 1'b0;
   logic [6:0] seconds_in = 7'h00;
   logic       pin_go = 1'b0;
   logic [7:0] pin_len = 8'h18;
   wire        sda_ce_in, scl_in, pin_done, reg_rvalid, chip_reset, centi_wrap;
   wire        soft_reset_cmd, divider_clear_cmd, ts_clear, reset_bypass_mode, reset_bypass_arm;
   wire        osc_halt_flag, clock_output_pin_en, hour_mode_24, temp_comp_en, centi_en;
   wire [2:0]  batt_mode;
   wire [7:0]  reg_rdata;
   wire [7:0]  modes = {clock_output_pin_en, hour_mode_24, temp_comp_en, centi_en, 1'b0, batt_mode};
   logic [7:0] codes [4] = '{8'ha4, 8'h25, 8'ha5, 8'h2c};
   logic [7:0] rd_val, v, e;
   int         err_total = 0;
   int         comparisons = 0;
   int         n;

   always #2.5 clk_sys = ~clk_sys;

   rtc_reset_and_osc_stop_control uut (.*);
   host_pin_model host (.clk_sys(clk_sys), .start(pin_go), .phase_len(pin_len), .sda_ce(sda_ce_in),
                        .scl(scl_in), .done(pin_done));

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // every access idles a cycle first so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys) #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys) #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk_sys) #1 reg_rd = 1'b0;
      d = reg_rdata;
      chk1(reg_rvalid, 1'b1);
   endtask
   task automatic tick();
      @(posedge clk_sys) #1 tick_centi = 1'b1;
      @(posedge clk_sys) #1 tick_centi = 1'b0;
   endtask
   task automatic wait_rst(input logic lvl);
      for (n = 0; chip_reset !== lvl && n < 60; n++) cyc(1);
      chk1(chip_reset, lvl);
   endtask
   task automatic pattern(input logic [7:0] len);
      pin_len = len;
      pin_go = 1'b1;
      for (n = 0; pin_done !== 1'b1 && n < 200; n++) cyc(1);
      pin_go = 1'b0;
      cyc(4);
   endtask

   function automatic logic [2:0] exp_cmd(input logic [7:0] c);
      case (c)
         8'h2c: return 3'b111;
         8'ha4: return 3'b010;
         8'h25: return 3'b001;
         8'ha5: return 3'b011;
         default: return 3'b000;
      endcase
   endfunction
   function automatic logic [7:0] bcd_inc(input logic [7:0] x);
      if (x[3:0] != 4'h9) return x + 8'h01;
      return (x[7:4] == 4'h9) ? 8'h00 : {x[7:4] + 4'h1, 4'h0};
   endfunction

   initial begin
      #100000;
      err_total++;
      give_verdict();
   end

   initial begin
      void'($urandom(24526));
      repeat (5) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      chk8(modes, 8'hf7);
      chk1(osc_halt_flag, 1'b1);
      cyc(40);
      chk1(chip_reset, 1'b1);
      osc_running_in = 1'b1;
      seconds_in = {3'($urandom % 6), 4'($urandom % 10)};
      wait_rst(1'b0); // fuse refresh by the host lives outside this block
      rd(8'h07, rd_val);
      chk8(rd_val, {1'b1, seconds_in});
      wr(8'h07, 8'h00);
      chk1(osc_halt_flag, 1'b0);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h98 : {4'($urandom % 10), 4'($urandom % 10)};
         wr(8'h06, v);
         repeat (2 + i % 3) begin
            tick();
            chk1(centi_wrap, v == 8'h99);
            v = bcd_inc(v);
         end
         rd(8'h06, rd_val);
         chk8(rd_val, v);
      end
      wr(8'h06, 8'h37);
      wr(8'h00, 8'h1e);
      chk8(modes, 8'h00);
      for (int i = 0; i < 9; i++) begin
         e = (i < 4) ? codes[i] : 8'($urandom);
         wr(8'h05, e); // stop bit is held outside this block
         chk8({5'h00, soft_reset_cmd, divider_clear_cmd, ts_clear}, {5'h00, exp_cmd(e)});
         rd(8'h05, rd_val);
         chk8(rd_val, 8'h24);
      end
      chk1(osc_halt_flag, 1'b1);
      chk8(modes, 8'hf7);
      rd(8'h06, rd_val);
      chk8(rd_val, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(8'h07, 8'h00);
         chk1(osc_halt_flag, 1'b0);
         if (i == 0) supply_ok_in = 1'b0;
         else osc_supply_ok_in = 1'b0;
         cyc(6);
         chk8({6'h00, chip_reset, osc_halt_flag}, 8'h03);
         supply_ok_in = 1'b1;
         osc_supply_ok_in = 1'b1;
         wait_rst(1'b0);
         chk1(osc_halt_flag, 1'b1);
      end
      wr(8'h00, 8'he1);
      chk1(reset_bypass_arm, 1'b1);
      osc_running_in = 1'b0;
      wait_rst(1'b1);
      pattern(8'h0a);
      chk1(reset_bypass_mode, 1'b0);
      pattern(8'h18);
      chk1(reset_bypass_mode, 1'b1);
      wait_rst(1'b0);
      wr(8'h05, 8'h2c);
      cyc(3);
      chk1(reset_bypass_mode, 1'b1);
      wr(8'h00, 8'he0);
      chk1(reset_bypass_arm, 1'b0);
      chk1(reset_bypass_mode, 1'b0);
      wait_rst(1'b1);
      pattern(8'h18);
      chk1(reset_bypass_mode, 1'b0);
      osc_running_in = 1'b1;
      wait_rst(1'b0);
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
